// *** design/nlc_pkg.sv ***
// Constants and types for the logic and constant-transfer execution block
package nlc_pkg;
  localparam int OPC_W = 9;
  localparam int NIB_W = 4;
  localparam int XADR_W = 4;
  // Full opcodes
  localparam logic [8:0] OPC_MEM_NE_ACC = 9'h009;
  localparam logic [8:0] OPC_MEM_NE_ZERO = 9'h033;
  localparam logic [8:0] OPC_YIDX_NE_ACC = 9'h002;
  localparam logic [8:0] OPC_OR_MEM_ACC = 9'h014;
  localparam logic [8:0] OPC_OR_MEM_INV = 9'h017;
  // Upper five bits of opcodes with a 4-bit constant field
  localparam logic [4:0] GRP_YIDX_NE_CONST = 5'h05;
  localparam logic [4:0] GRP_CONST_TO_ACC = 5'h0c;
  localparam logic [4:0] GRP_CONST_TO_YIDX = 5'h04;
  localparam logic [4:0] GRP_CONST_TO_MEM = 5'h06;
  // Upper seven bits of opcodes with a 2-bit bit-select field
  localparam logic [6:0] GRP_MEM_BIT_SET = 7'h28;
  localparam logic [6:0] GRP_MEM_BIT_CLEAR = 7'h29;
  localparam logic [6:0] GRP_ACC_BIT_FLAG = 7'h2a;
  localparam logic [6:0] GRP_MEM_BIT_FLAG = 7'h08;
  // Reset values and nibble constants
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [3:0] YIDX_RST = 4'h0;
  localparam logic STATUS_RST = 1'b1;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] NIB_ONE = 4'h1;
  typedef enum logic [1:0] {NLC_ST_IDLE, NLC_ST_READ, NLC_ST_EXEC} nlc_state_t;
endpackage : nlc_pkg

// *** design/nlc_alu.sv ***
// Opcode decode and result computation for one instruction
`timescale 1ns/10ps
`default_nettype none
module nlc_alu (
  input wire logic [8:0] opcode, // Instruction under execution
  input wire logic [3:0] acc, // Accumulator
  input wire logic [3:0] yidx, // Y register
  input wire logic [3:0] mem, // Addressed RAM nibble
  input wire logic status, // Current status flag
  output logic hit, // Opcode belongs to this group
  output logic flag, // Next status value
  output logic [3:0] acc_out, // Next accumulator
  output logic [3:0] yidx_out, // Next Y
  output logic [3:0] mem_out, // Nibble to write back
  output logic mem_we // Write the nibble back
);
  logic [3:0] cfield;
  logic [1:0] bsel;
  always_comb begin
    cfield = opcode[3:0];
    bsel = opcode[1:0];
    hit = 1'b1;
    flag = 1'b1;
    acc_out = acc;
    yidx_out = yidx;
    mem_out = mem;
    mem_we = 1'b0;
    if (opcode == nlc_pkg::OPC_MEM_NE_ACC) begin
      flag = (mem != acc);
    end else if (opcode == nlc_pkg::OPC_MEM_NE_ZERO) begin
      flag = (mem != nlc_pkg::NIB_ZERO);
    end else if (opcode == nlc_pkg::OPC_YIDX_NE_ACC) begin
      flag = (yidx != acc);
    end else if (opcode == nlc_pkg::OPC_OR_MEM_ACC) begin
      acc_out = mem | acc;
    end else if (opcode == nlc_pkg::OPC_OR_MEM_INV) begin
      acc_out = mem | ~acc;
    end else if (opcode[8:4] == nlc_pkg::GRP_YIDX_NE_CONST) begin
      flag = (yidx != cfield);
    end else if (opcode[8:4] == nlc_pkg::GRP_CONST_TO_ACC) begin
      acc_out = cfield;
    end else if (opcode[8:4] == nlc_pkg::GRP_CONST_TO_YIDX) begin
      yidx_out = cfield;
    end else if (opcode[8:4] == nlc_pkg::GRP_CONST_TO_MEM) begin
      mem_out = cfield;
      mem_we = 1'b1;
      yidx_out = yidx + nlc_pkg::NIB_ONE;
    end else if (opcode[8:2] == nlc_pkg::GRP_MEM_BIT_SET) begin
      mem_out[bsel] = 1'b1;
      mem_we = 1'b1;
    end else if (opcode[8:2] == nlc_pkg::GRP_MEM_BIT_CLEAR) begin
      mem_out[bsel] = 1'b0;
      mem_we = 1'b1;
    end else if (opcode[8:2] == nlc_pkg::GRP_MEM_BIT_FLAG) begin
      flag = mem[bsel];
    end else if (opcode[8:2] == nlc_pkg::GRP_ACC_BIT_FLAG) begin
      flag = acc[bsel];
    end else begin
      hit = 1'b0;
      flag = status;
    end
  end
endmodule : nlc_alu
`default_nettype wire

// *** design/nlc_exec.sv ***
// Execution unit for logical compares, bit operations and constant loads
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Opcode 009: status is one when addressed nibble differs from accumulator
// - Opcode 033: status is one when addressed nibble is nonzero
// - Opcode 002: status is one when Y differs from accumulator
// - Opcodes 050-05F: status is one when Y differs from constant
// - Opcodes 0A0-0A3: set selected bit of addressed nibble, keep others
// - Opcodes 0A4-0A7: clear selected bit of addressed nibble, keep others
// - Opcodes 020-023: status takes selected bit of addressed nibble
// - Opcodes 0A8-0AB: status takes selected accumulator bit
// - Opcode 014: accumulator becomes nibble OR accumulator
// - Opcode 017: accumulator becomes nibble OR inverted accumulator
// - Opcodes 0C0-0CF: accumulator loads the constant
// - Opcodes 040-04F: Y loads the constant
// - Opcodes 060-06F: constant stored at X,Y, then Y increments
module nlc_exec (
  input wire logic ref_clk, // Processor clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic instr_valid, // Opcode offered
  input wire logic [8:0] instr_opcode, // Opcode from program memory
  output logic instr_ready, // Unit can take an opcode
  input wire logic [3:0] x_idx, // X register, register select
  output logic [7:0] ram_addr, // RAM address {X, Y}
  output logic ram_rd_en, // RAM read strobe
  input wire logic [3:0] ram_rdata, // RAM data, one cycle after strobe
  output logic ram_we, // RAM write strobe
  output logic [3:0] ram_wdata, // RAM write data
  output logic [3:0] acc, // Accumulator
  output logic [3:0] yidx, // Y register
  output logic status, // Status flag
  output logic done, // Instruction retired
  output logic op_hit // Retired opcode was in this group
);
  nlc_pkg::nlc_state_t state_r, state_nxt;
  logic [8:0] op_r, op_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic rd_r, rd_nxt;
  logic we_r, we_nxt;
  logic [3:0] wdata_r, wdata_nxt;
  logic [3:0] acc_r, acc_nxt;
  logic [3:0] y_r, y_nxt;
  logic st_r, st_nxt;
  logic done_r, done_nxt;
  logic hit_r, hit_nxt;
  logic a_hit, a_flag, a_mem_we;
  logic [3:0] a_acc, a_y, a_mem;
  // Snapshot of operands at retirement, read by the checks below
  logic [3:0] sn_acc_r, sn_y_r, sn_mem_r;
  logic [3:0] sn_acc_nxt, sn_y_nxt, sn_mem_nxt;

  nlc_alu u_alu (
    .opcode(op_r),
    .acc(acc_r),
    .yidx(y_r),
    .mem(ram_rdata),
    .status(st_r),
    .hit(a_hit),
    .flag(a_flag),
    .acc_out(a_acc),
    .yidx_out(a_y),
    .mem_out(a_mem),
    .mem_we(a_mem_we)
  );

  assign instr_ready = (state_r == nlc_pkg::NLC_ST_IDLE);
  assign ram_addr = addr_r;
  assign ram_rd_en = rd_r;
  assign ram_we = we_r;
  assign ram_wdata = wdata_r;
  assign acc = acc_r;
  assign yidx = y_r;
  assign status = st_r;
  assign done = done_r;
  assign op_hit = hit_r;

  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    rd_nxt = 1'b0;
    we_nxt = 1'b0;
    wdata_nxt = wdata_r;
    acc_nxt = acc_r;
    y_nxt = y_r;
    st_nxt = st_r;
    done_nxt = 1'b0;
    hit_nxt = hit_r;
    sn_acc_nxt = sn_acc_r;
    sn_y_nxt = sn_y_r;
    sn_mem_nxt = sn_mem_r;
    unique case (state_r)
      nlc_pkg::NLC_ST_IDLE: begin
        if (instr_valid) begin
          op_nxt = instr_opcode;
          addr_nxt = {x_idx, y_r};
          rd_nxt = 1'b1;
          state_nxt = nlc_pkg::NLC_ST_READ;
        end
      end
      nlc_pkg::NLC_ST_READ: begin
        state_nxt = nlc_pkg::NLC_ST_EXEC;
      end
      nlc_pkg::NLC_ST_EXEC: begin
        acc_nxt = a_acc;
        y_nxt = a_y;
        st_nxt = a_flag;
        we_nxt = a_mem_we;
        wdata_nxt = a_mem;
        done_nxt = 1'b1;
        hit_nxt = a_hit;
        sn_acc_nxt = acc_r;
        sn_y_nxt = y_r;
        sn_mem_nxt = ram_rdata;
        state_nxt = nlc_pkg::NLC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= nlc_pkg::NLC_ST_IDLE;
      op_r <= '0;
      addr_r <= '0;
      rd_r <= 1'b0;
      we_r <= 1'b0;
      wdata_r <= nlc_pkg::NIB_ZERO;
      acc_r <= nlc_pkg::ACC_RST;
      y_r <= nlc_pkg::YIDX_RST;
      st_r <= nlc_pkg::STATUS_RST;
      done_r <= 1'b0;
      hit_r <= 1'b0;
      sn_acc_r <= nlc_pkg::NIB_ZERO;
      sn_y_r <= nlc_pkg::NIB_ZERO;
      sn_mem_r <= nlc_pkg::NIB_ZERO;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      rd_r <= rd_nxt;
      we_r <= we_nxt;
      wdata_r <= wdata_nxt;
      acc_r <= acc_nxt;
      y_r <= y_nxt;
      st_r <= st_nxt;
      done_r <= done_nxt;
      hit_r <= hit_nxt;
      sn_acc_r <= sn_acc_nxt;
      sn_y_r <= sn_y_nxt;
      sn_mem_r <= sn_mem_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Retire checks against the operand snapshot
  mem_ne_acc_a: assert property (done && op_r == nlc_pkg::OPC_MEM_NE_ACC
      |-> st_r == (sn_mem_r != sn_acc_r))
    else $error("mem_ne_acc_test status wrong");
  mem_ne_zero_a: assert property (done && op_r == nlc_pkg::OPC_MEM_NE_ZERO
      |-> st_r == (sn_mem_r != nlc_pkg::NIB_ZERO))
    else $error("mem_ne_zero_test status wrong");
  yidx_ne_acc_a: assert property (done && op_r == nlc_pkg::OPC_YIDX_NE_ACC
      |-> st_r == (sn_y_r != sn_acc_r))
    else $error("yidx_ne_acc_test status wrong");
  yidx_ne_const_a: assert property (done && op_r[8:4] == nlc_pkg::GRP_YIDX_NE_CONST
      |-> st_r == (sn_y_r != op_r[3:0]))
    else $error("yidx_ne_const_test status wrong");
  cmp_keep_a: assert property (done && (op_r == nlc_pkg::OPC_MEM_NE_ACC
      || op_r == nlc_pkg::OPC_MEM_NE_ZERO || op_r == nlc_pkg::OPC_YIDX_NE_ACC
      || op_r[8:4] == nlc_pkg::GRP_YIDX_NE_CONST)
      |-> acc_r == sn_acc_r && yidx == sn_y_r && !ram_we)
    else $error("compare changed data");
  bit_set_a: assert property (done && op_r[8:2] == nlc_pkg::GRP_MEM_BIT_SET
      |-> ram_we && ram_wdata == (sn_mem_r | (nlc_pkg::NIB_ONE << op_r[1:0])) && st_r)
    else $error("mem_bit_set result wrong");
  bit_clear_a: assert property (done && op_r[8:2] == nlc_pkg::GRP_MEM_BIT_CLEAR
      |-> ram_we && ram_wdata == (sn_mem_r & ~(nlc_pkg::NIB_ONE << op_r[1:0])))
    else $error("mem_bit_clear result wrong");
  bit_flag_a: assert property (done && op_r[8:2] == nlc_pkg::GRP_MEM_BIT_FLAG
      |-> st_r == sn_mem_r[op_r[1:0]] && !ram_we)
    else $error("mem_bit_to_flag status wrong");
  acc_flag_a: assert property (done && op_r[8:2] == nlc_pkg::GRP_ACC_BIT_FLAG
      |-> st_r == sn_acc_r[op_r[1:0]] && acc_r == sn_acc_r)
    else $error("acc_bit_to_flag status wrong");
  or_acc_a: assert property (done && op_r == nlc_pkg::OPC_OR_MEM_ACC
      |-> acc_r == (sn_mem_r | sn_acc_r) && st_r)
    else $error("or_mem_into_acc result wrong");
  or_inv_a: assert property (done && op_r == nlc_pkg::OPC_OR_MEM_INV
      |-> acc_r == (sn_mem_r | ~sn_acc_r) && st_r)
    else $error("or_mem_inv_acc result wrong");
  or_keep_a: assert property (done && (op_r == nlc_pkg::OPC_OR_MEM_ACC
      || op_r == nlc_pkg::OPC_OR_MEM_INV) |-> yidx == sn_y_r && !ram_we)
    else $error("logical OR touched Y or memory");
  const_acc_a: assert property (done && op_r[8:4] == nlc_pkg::GRP_CONST_TO_ACC
      |-> acc_r == op_r[3:0] && st_r)
    else $error("const_to_acc result wrong");
  const_y_a: assert property (done && op_r[8:4] == nlc_pkg::GRP_CONST_TO_YIDX
      |-> yidx == op_r[3:0] && st_r && !ram_we)
    else $error("const_to_yidx result wrong");
  const_mem_a: assert property (done && op_r[8:4] == nlc_pkg::GRP_CONST_TO_MEM
      |-> ram_we && ram_wdata == op_r[3:0] && ram_addr[3:0] == sn_y_r
          && yidx == 4'(sn_y_r + nlc_pkg::NIB_ONE) && st_r)
    else $error("const_to_mem_inc_y result wrong");
  read_seq_a: assert property (instr_valid && instr_ready
      |=> ram_rd_en ##1 !ram_rd_en ##1 done)
    else $error("read and retire sequence out of step");
  busy_refuse_a: assert property (instr_valid && instr_ready
      |=> !instr_ready [*2] ##1 instr_ready)
    else $error("ready not low while busy");
  miss_keep_a: assert property (done && !op_hit
      |-> st_r == $past(st_r, 1) && !ram_we && acc_r == sn_acc_r && yidx == sn_y_r)
    else $error("foreign opcode changed state");

  cover_mem_write_c: cover property (done && ram_we);
  cover_flag_zero_c: cover property (done && op_hit && !status);
  cover_back_to_back_c: cover property (done && instr_valid && instr_ready);
  cover_foreign_c: cover property (done && !op_hit);
  cover_yidx_wrap_c: cover property (done && op_r[8:4] == nlc_pkg::GRP_CONST_TO_MEM
      && yidx == nlc_pkg::NIB_ZERO);
endmodule : nlc_exec
`default_nettype wire

// *** sim/nlc_ram_model.sv ***
// Behavioural nibble RAM on the far side of the execution unit
`timescale 1ns/10ps
`default_nettype none
module nlc_ram_model (
  input wire logic ref_clk, // Processor clock
  input wire logic [7:0] ram_addr, // Address {X, Y}
  input wire logic ram_rd_en, // Read strobe
  output logic [3:0] ram_rdata, // Read data, one cycle later
  input wire logic ram_we, // Write strobe
  input wire logic [3:0] ram_wdata // Write data
);
  logic [3:0] mem_r [256];
  initial begin
    foreach (mem_r[i]) mem_r[i] = 4'h0;
    ram_rdata = 4'h5;
  end
  // Data only valid the cycle after a strobe, toggles otherwise
  always @(posedge ref_clk) begin
    if (ram_we === 1'b1) mem_r[ram_addr] <= ram_wdata;
    if (ram_rd_en === 1'b1) ram_rdata <= mem_r[ram_addr];
    else ram_rdata <= ~ram_rdata;
  end
endmodule : nlc_ram_model
`default_nettype wire

// *** sim/nlc_exec_tb.sv ***
// Self-checking bench for the logic and constant-transfer unit
`timescale 1ns/10ps
`default_nettype none
module nlc_exec_tb;
  logic ref_clk, rst_n, instr_valid, instr_ready, ram_rd_en, ram_we;
  logic status, done, op_hit;
  logic [8:0] instr_opcode;
  logic [3:0] x_idx, ram_rdata, ram_wdata, acc, yidx;
  logic [7:0] ram_addr;
  logic [3:0] acc_s, y_s, mem_s [256];
  logic st_s;
  logic [22:0] exp_q [$];
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  nlc_exec nlc_exec_inst (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_opcode(instr_opcode), .instr_ready(instr_ready), .x_idx(x_idx),
    .ram_addr(ram_addr), .ram_rd_en(ram_rd_en), .ram_rdata(ram_rdata), .ram_we(ram_we),
    .ram_wdata(ram_wdata), .acc(acc), .yidx(yidx), .status(status), .done(done),
    .op_hit(op_hit));
  nlc_ram_model nlc_ram_model_inst (.ref_clk(ref_clk), .ram_addr(ram_addr),
    .ram_rd_en(ram_rd_en), .ram_rdata(ram_rdata), .ram_we(ram_we), .ram_wdata(ram_wdata));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [22:0] seen, input logic [22:0] expd);
    tests_run++;
    if (seen !== expd) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expd);
    end
  endtask : check
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Offer one opcode and note the expected retire values
  task automatic issue(input logic [8:0] op, input logic [3:0] x);
    logic [3:0] m, c, na, ny, wd;
    logic ns, hit, we;
    logic [1:0] b;
    @(negedge ref_clk);
    instr_valid <= 1'b1;
    instr_opcode <= op;
    x_idx <= x;
    while (instr_ready !== 1'b1) @(negedge ref_clk);
    m = mem_s[{x, y_s}];
    c = op[3:0];
    b = op[1:0];
    ns = 1'b1;
    na = acc_s;
    ny = y_s;
    hit = 1'b1;
    we = 1'b0;
    wd = 4'h0;
    if (op == 9'h009) ns = (m != acc_s);
    else if (op == 9'h033) ns = (m != 4'h0);
    else if (op == 9'h002) ns = (y_s != acc_s);
    else if (op[8:4] == 5'h05) ns = (y_s != c);
    else if (op[8:2] == 7'h28) begin we = 1'b1; wd = m | (4'h1 << b); end
    else if (op[8:2] == 7'h29) begin we = 1'b1; wd = m & ~(4'h1 << b); end
    else if (op[8:2] == 7'h08) ns = m[b];
    else if (op[8:2] == 7'h2a) ns = acc_s[b];
    else if (op == 9'h014) na = m | acc_s;
    else if (op == 9'h017) na = m | ~acc_s;
    else if (op[8:4] == 5'h0c) na = c;
    else if (op[8:4] == 5'h04) ny = c;
    else if (op[8:4] == 5'h06) begin we = 1'b1; wd = c; ny = y_s + 4'h1; end
    else begin hit = 1'b0; ns = st_s; end
    exp_q.push_back({hit, we, wd, na, ny, ns, x, y_s});
    if (we) mem_s[{x, y_s}] = wd;
    acc_s = na;
    y_s = ny;
    st_s = ns;
    @(posedge ref_clk);
    @(negedge ref_clk);
    instr_valid <= 1'b0;
  endtask : issue
  // Result watcher: every retire is matched against the oldest note
  always @(negedge ref_clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) check(23'h7f_ffff, 23'h00_0000);
      else check({op_hit, ram_we, (ram_we ? ram_wdata : 4'h0), acc, yidx, status, ram_addr},
        exp_q.pop_front());
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 12000) begin
      error_cnt++;
      $display("MISMATCH t=%0t run did not finish", $time);
      report_and_stop();
    end
  end
  initial begin
    int seed;
    logic [8:0] base [13];
    logic [8:0] mask [13];
    int k;
    seed = $urandom(93642);
    base = '{9'h009, 9'h033, 9'h002, 9'h050, 9'h0a0, 9'h0a4, 9'h020, 9'h0a8, 9'h014,
      9'h017, 9'h0c0, 9'h040, 9'h060};
    mask = '{9'h000, 9'h000, 9'h000, 9'h00f, 9'h003, 9'h003, 9'h003, 9'h003, 9'h000,
      9'h000, 9'h00f, 9'h00f, 9'h00f};
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_opcode = 9'h000;
    x_idx = 4'h0;
    foreach (mem_s[i]) mem_s[i] = 4'h0;
    acc_s = 4'h0;
    y_s = 4'h0;
    st_s = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    check({1'b0, acc, yidx, status, instr_ready, ram_rd_en, ram_we, done, op_hit, ram_addr},
      {1'b0, 4'h0, 4'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00});
    $display("Test reset values done");
    for (int op = 0; op < 512; op++) issue(op[8:0], 4'($urandom));
    $display("Test opcode sweep done");
    for (int n = 0; n < 400; n++) begin
      k = $urandom % 13;
      if (n % 5 == 0) k = 12;
      issue(base[k] | (9'($urandom) & mask[k]), 4'($urandom % 2));
    end
    $display("Test random mix done");
    k = 0;
    while (exp_q.size() != 0 && k < 20) begin
      @(negedge ref_clk);
      k++;
    end
    repeat (2) @(negedge ref_clk);
    if (exp_q.size() != 0) check(23'(exp_q.size()), 23'h00_0000);
    report_and_stop();
  end
endmodule : nlc_exec_tb
`default_nettype wire
